// ---- dv/dram_rom_memory_interface_props.sv ----
// pin protocol assertions for the memory interface
`timescale 1ns/10ps
`default_nettype none
module dram_rom_memory_interface_props
  import mem_if_pkg::*;
#(
  parameter int REFI = 40
) (
  input wire logic                sys_clk,
  input wire logic                rst_b,
  input wire logic                romIsFlash,
  input wire logic                romBank0Byte,
  input wire logic                suspend,
  input wire logic                refreshSlowClk,
  input wire logic                reqValid,
  input wire logic                reqReady,
  input wire logic                reqWrite,
  input wire logic                reqRom,
  input wire logic                rspDone,
  input wire logic                rspRefused,
  input wire logic [0:ADDR_W-1]   memAddr,
  input wire logic [0:STROBE_N-1] rowStrobeB,
  input wire logic [0:STROBE_N-1] colStrobeB,
  input wire logic                memWriteEnB,
  input wire logic                flashOutEnB,
  input wire logic                romBank0SelB,
  input wire logic                romBank1SelB,
  input wire logic                memDataLatchEn,
  input wire logic                parityPathRdEn,
  input wire logic [0:1]          bufferCtrl,
  input wire logic                parityOe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  wire logic romSel = !(romBank0SelB && romBank1SelB);
  wire logic colOn = colStrobeB != STROBE_OFF;

  sequence takeDram;
    reqValid && reqReady && !reqRom;
  endsequence
  sequence rowOpen;
    rowStrobeB != STROBE_OFF && colStrobeB == STROBE_OFF;
  endsequence
  sequence colOpen;
    colStrobeB != STROBE_OFF && rowStrobeB != STROBE_OFF;
  endsequence

  dram_order_a: assert property (takeDram |-> ##2 rowOpen ##4 colOpen ##3 rspDone)
    else $error("dram access phases out of order or late");
  rom_done_a: assert property (reqValid && reqReady && reqRom && (!reqWrite || romIsFlash)
    |-> ##25 rspDone)
    else $error("rom access did not finish on time");
  rom_refuse_a: assert property (reqValid && reqReady && reqRom && reqWrite && !romIsFlash
    |-> ##[1:2] (rspRefused && rspDone))
    else $error("plain rom write not refused");
  col_parity_a: assert property (colOn |-> parityOe == !memWriteEnB)
    else $error("parity direction wrong in column phase");
  read_path_a: assert property (colOn && memWriteEnB
    |-> memDataLatchEn && parityPathRdEn && bufferCtrl == 2'h1)
    else $error("read enables missing");
  write_path_a: assert property (colOn && !memWriteEnB
    |-> bufferCtrl == 2'h3 && !memDataLatchEn && !parityPathRdEn)
    else $error("write buffer control wrong");
  flash_oe_a: assert property (!flashOutEnB
    |-> romIsFlash && memWriteEnB && romBank0SelB != romBank1SelB)
    else $error("flash output enable outside flash read");
  rom_write_a: assert property (romSel && !memWriteEnB
    |-> romIsFlash && romBank0SelB != romBank1SelB)
    else $error("write to plain rom or two banks");
  extra_bit_a: assert property (romSel && (!romBank1SelB || !romBank0Byte)
    |-> !memAddr[0] && parityOe)
    else $error("extra rom bit or low rom lines wrong");
  susp_hold_a: assert property (suspend |=> !reqReady)
    else $error("request accepted in suspend");
  slow_ref_a: assert property (suspend && $rose(refreshSlowClk)
    |-> ##[1:40] rowStrobeB == 8'h00)
    else $error("slow clock did not start a refresh");
endmodule

bind dram_rom_memory_interface dram_rom_memory_interface_props #(.REFI(REFI)) u_props (
  .sys_clk(sys_clk), .rst_b(rst_b), .romIsFlash(romIsFlash), .romBank0Byte(romBank0Byte),
  .suspend(suspend), .refreshSlowClk(refreshSlowClk), .reqValid(reqValid),
  .reqReady(reqReady), .reqWrite(reqWrite), .reqRom(reqRom), .rspDone(rspDone),
  .rspRefused(rspRefused), .memAddr(memAddr), .rowStrobeB(rowStrobeB),
  .colStrobeB(colStrobeB), .memWriteEnB(memWriteEnB), .flashOutEnB(flashOutEnB),
  .romBank0SelB(romBank0SelB), .romBank1SelB(romBank1SelB),
  .memDataLatchEn(memDataLatchEn), .parityPathRdEn(parityPathRdEn),
  .bufferCtrl(bufferCtrl), .parityOe(parityOe));
`default_nettype wire

// ---- dv/dram_rom_memory_interface_tb_top.sv ----
// self-checking bench for the memory pin interface
`timescale 1ns/10ps
`default_nettype none
module dram_rom_memory_interface_tb_top
  import mem_if_pkg::*;
();
  localparam logic [0:12] ROW = 13'h1a53;
  localparam logic [0:12] COL = 13'h0c3a;
  localparam logic [0:7]  WP  = 8'h96;
  logic sys_clk = 1'h0, rst_b = 1'h0, ramIsEdo = 1'h0, romIsFlash = 1'h0;
  logic romBank0Byte = 1'h0, suspend = 1'h0, refreshSlowClk = 1'h0, reqValid = 1'h0;
  logic reqWrite = 1'h0, reqRom = 1'h0, reqRomBank = 1'h0;
  logic [BANK_W-1:0]     reqBank = '0;
  logic [0:STROBE_N-1]   reqByteEn = '0, rowStrobeB, colStrobeB;
  logic [0:ROM_ADDR_W-1] reqRomAddr = '0;
  logic [0:PARITY_W-1]   rspParity, parityOut, parityIn, parityDrive;
  logic [0:ADDR_W-1]     memAddr;
  logic [0:1]            bufferCtrl;
  logic reqReady, rspDone, rspRefused, memWriteEnB, flashOutEnB, romBank0SelB;
  logic romBank1SelB, memDataLatchEn, parityPathRdEn, parityOe;
  int n_fail = 0, num_checks = 0, cyc = 0;

  always #2.5 sys_clk = ~sys_clk;
  // the shared lines carry whichever side has them enabled
  assign parityIn = parityOe ? parityOut : parityDrive;

  dram_rom_memory_interface #(.REFI(40)) u_dram_rom_memory_interface (
    .sys_clk(sys_clk), .rst_b(rst_b), .ramIsEdo(ramIsEdo), .romIsFlash(romIsFlash),
    .romBank0Byte(romBank0Byte), .suspend(suspend), .refreshSlowClk(refreshSlowClk),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqRom(reqRom), .reqRomBank(reqRomBank),
    .reqBank(reqBank), .reqRowAddr(ROW), .reqColAddr(COL), .reqByteEn(reqByteEn),
    .reqRomAddr(reqRomAddr), .reqWrParity(WP), .reqReady(reqReady), .rspDone(rspDone),
    .rspRefused(rspRefused), .rspParity(rspParity), .memAddr(memAddr),
    .rowStrobeB(rowStrobeB), .colStrobeB(colStrobeB), .memWriteEnB(memWriteEnB),
    .flashOutEnB(flashOutEnB), .romBank0SelB(romBank0SelB), .romBank1SelB(romBank1SelB),
    .memDataLatchEn(memDataLatchEn), .parityPathRdEn(parityPathRdEn),
    .bufferCtrl(bufferCtrl), .parityOut(parityOut), .parityOe(parityOe),
    .parityIn(parityIn));

  mem_partner_model u_mem_partner_model (.sys_clk(sys_clk), .memAddr(memAddr),
    .colStrobeB(colStrobeB), .memWriteEnB(memWriteEnB), .parityDrive(parityDrive));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // holds the request until a ready edge, drops it on that edge, returns mid-cycle after it
  task automatic issue(input logic w, r, rb, input logic [2:0] bk, input logic [0:7] ln,
                       input logic [0:20] ra);
    @(posedge sys_clk);
    reqWrite <= w;
    reqRom <= r;
    reqRomBank <= rb;
    reqBank <= bk;
    reqByteEn <= ln;
    reqRomAddr <= ra;
    reqValid <= 1'h1;
    do @(negedge sys_clk); while (reqReady !== 1'h1);
    @(posedge sys_clk);
    reqValid <= 1'h0;
    @(negedge sys_clk);
  endtask

  // k counts cycles after the take edge; stops early at the done pulse
  task automatic adv(inout int k, input int t);
    while (k < t && rspDone !== 1'h1) begin
      @(posedge sys_clk);
      @(negedge sys_clk);
      k++;
    end
  endtask

  task automatic t_dram(input logic w, edo, input logic [2:0] bk, input logic [0:7] ln);
    int k = 0;
    @(posedge sys_clk);
    ramIsEdo <= edo;
    issue(w, 1'h0, 1'h0, bk, ln, '0);
    adv(k, 2);
    chk("row addr", ROW, memAddr);
    chk("row strobe", 32'h0, rowStrobeB[bk]);
    chk("col idle", STROBE_OFF, colStrobeB);
    chk("dram we", !w, memWriteEnB);
    adv(k, 6);
    chk("col addr", COL, memAddr);
    chk("col strobe", 8'(~ln), colStrobeB);
    chk("buffers", {w, 1'h1}, bufferCtrl);
    chk("rd enables", {!w, !w}, {memDataLatchEn, parityPathRdEn});
    chk("parity oe", w, parityOe);
    if (w) chk("parity out", WP, parityOut);
    adv(k, 40);
    chk("dram done", 32'h8, k);
    chk("edo latch", edo & !w, memDataLatchEn);
    if (!w) chk("rd parity", COL[5:12] ^ 8'h3c, rspParity);
    $display("test dram write=%0d bank=%0d done", w, bk);
  endtask

  task automatic t_rom(input logic fl, w, rb, byt, input logic [0:20] ra);
    int k = 0;
    logic ok;
    ok = !w || fl;
    @(posedge sys_clk);
    romIsFlash <= fl;
    romBank0Byte <= byt;
    issue(w, 1'h1, rb, 3'h0, '0, ra);
    adv(k, 3);
    if (ok) begin
      chk("rom high", ra[9:20], memAddr[1:12]);
      chk("rom extra", ra[0] & !rb & byt, memAddr[0]);
      chk("rom low", {1'h1, ra[1:8]}, {parityOe, parityOut});
      chk("bank sel", {rb, !rb}, {romBank0SelB, romBank1SelB});
      chk("flash oe", !(fl & !w), flashOutEnB);
      chk("rom we", !w, memWriteEnB);
    end
    adv(k, 40);
    chk("rom done", ok ? 32'h18 : 32'h0, k);
    chk("refused", !ok, rspRefused);
    $display("test rom flash=%0d write=%0d bank=%0d done", fl, w, rb);
  endtask

  task automatic t_susp();
    int k = 0;
    @(posedge sys_clk);
    suspend <= 1'h1;
    // long enough for any refresh already running to close
    repeat (30) @(posedge sys_clk);
    refreshSlowClk <= 1'h1;
    do begin
      @(negedge sys_clk);
      k++;
    end while (rowStrobeB !== 8'h00 && k < 40);
    chk("susp refresh", 8'h00, rowStrobeB);
    chk("susp ready", 32'h0, reqReady);
    @(posedge sys_clk);
    refreshSlowClk <= 1'h0;
    suspend <= 1'h0;
    $display("test suspend done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 5000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'h1;
    t_dram(1'h0, 1'h0, 3'h7, 8'h81);
    t_dram(1'h1, 1'h0, 3'h0, 8'hff);
    t_dram(1'h0, 1'h1, 3'h3, 8'h3c);
    t_rom(1'h0, 1'h0, 1'h0, 1'h1, 21'h1a5c3b);
    t_rom(1'h0, 1'h1, 1'h0, 1'h1, 21'h1a5c3b);
    t_rom(1'h1, 1'h0, 1'h1, 1'h1, 21'h1f00a5);
    t_rom(1'h1, 1'h1, 1'h0, 1'h0, 21'h1f00a5);
    t_susp();
    report_and_stop();
  end
endmodule
`default_nettype wire

// ---- dv/mem_partner_model.sv ----
// memory-side model: answers parity on dram reads, scrambles the released lines
`timescale 1ns/10ps
`default_nettype none
module mem_partner_model
  import mem_if_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic [0:ADDR_W-1]   memAddr,
  input  wire logic [0:STROBE_N-1] colStrobeB,
  input  wire logic                memWriteEnB,
  output logic      [0:PARITY_W-1] parityDrive
);
  logic [0:PARITY_W-1] lastVal = 8'h00;
  wire logic        rdCol;

  // the stored parity is tied to the column so a stale capture shows
  assign rdCol = (colStrobeB != STROBE_OFF) && memWriteEnB;
  // released lines never repeat the last value, so a late sample is caught
  assign parityDrive = rdCol ? (memAddr[5:12] ^ 8'h3c) : ~lastVal;

  always_ff @(posedge sys_clk) begin
    lastVal <= parityDrive;
  end
endmodule
`default_nettype wire

// ---- logic/dram_rom_memory_interface.sv ----
// dram and rom/flash pin sequencer with parity path and refresh
//
// Overview of operation
// - dram may be standard or edo and rom may be plain or flash, and pin use follows that choice.
// - the dram address goes out row then column on thirteen address lines, line 0 most significant.
// - on rom accesses line 0 carries the extra rom bit and lines 1 to 12 carry rom bits 9 to 20.
// - rom bits 9 to 20 are the lowest order rom bits, with bit 20 the least significant.
// - rom bits 1 to 8 go out on the parity lines during every rom or flash access.
// - the extra rom bit is driven only for bank 0 set to byte width, reaching 2 Mbytes.
// - two buffer control outputs steer direction and enable of the external data buffers.
// - eight column strobes mark the column address, strobe 0 on the top byte lane.
// - eight row strobes mark the row address, each selecting its own bank.
// - the flash output enable is active only during a flash read.
// - the data latch enable is active during memory reads.
// - parity goes out on dram writes and is taken in on dram reads, bit 0 most significant.
// - the parity path read enable is active during dram reads only, not rom or flash reads.
// - two bank selects pick rom banks for reads and flash banks for reads or writes.
// - in suspend, refresh is paced by the external slow clock input.
// - write enable is active for writes to dram, edo dram or flash.
`timescale 1ns/10ps
`default_nettype none
module dram_rom_memory_interface
  import mem_if_pkg::*;
#(
  parameter int REFI = REFI_CYC
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire logic                  ramIsEdo,
  input  wire logic                  romIsFlash,
  input  wire logic                  romBank0Byte,
  input  wire logic                  suspend,
  input  wire logic                  refreshSlowClk,
  input  wire logic                  reqValid,
  input  wire logic                  reqWrite,
  input  wire logic                  reqRom,
  input  wire logic                  reqRomBank,
  input  wire logic [BANK_W-1:0]     reqBank,
  input  wire logic [0:ADDR_W-1]     reqRowAddr,
  input  wire logic [0:ADDR_W-1]     reqColAddr,
  input  wire logic [0:STROBE_N-1]   reqByteEn,
  input  wire logic [0:ROM_ADDR_W-1] reqRomAddr,
  input  wire logic [0:PARITY_W-1]   reqWrParity,
  output logic                       reqReady,
  output logic                       rspDone,
  output logic                       rspRefused,
  output logic      [0:PARITY_W-1]   rspParity,
  output logic      [0:ADDR_W-1]     memAddr,
  output logic      [0:STROBE_N-1]   rowStrobeB,
  output logic      [0:STROBE_N-1]   colStrobeB,
  output logic                       memWriteEnB,
  output logic                       flashOutEnB,
  output logic                       romBank0SelB,
  output logic                       romBank1SelB,
  output logic                       memDataLatchEn,
  output logic                       parityPathRdEn,
  output logic      [0:1]            bufferCtrl,
  output logic      [0:PARITY_W-1]   parityOut,
  output logic                       parityOe,
  input  wire logic [0:PARITY_W-1]   parityIn
);

  mem_state_t state;
  mem_state_t nextState;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] nextCnt;
  logic             accept;
  logic             refuse;
  logic             refreshTaken;
  logic             refreshPending;
  logic             refreshCycle;

  // held request, captured at acceptance
  logic                  heldWrite;
  logic                  heldRom;
  logic                  heldRomBank;
  logic [BANK_W-1:0]     heldBank;
  logic [0:ADDR_W-1]     heldRow;
  logic [0:ADDR_W-1]     heldCol;
  logic [0:STROBE_N-1]   heldByteEn;
  logic [0:ROM_ADDR_W-1] heldRomAddr;
  logic [0:PARITY_W-1]   heldWrParity;
  logic [0:ADDR_W-1]     refRow;

  // the request fields in force for the next cycle's pins
  wire logic                  curWrite   = accept ? reqWrite : heldWrite;
  wire logic                  curRomBank = accept ? reqRomBank : heldRomBank;
  wire logic [BANK_W-1:0]     curBank    = accept ? reqBank : heldBank;
  wire logic [0:ADDR_W-1]     curRow     = accept ? reqRowAddr : heldRow;
  wire logic [0:ADDR_W-1]     curCol     = accept ? reqColAddr : heldCol;
  wire logic [0:STROBE_N-1]   curByteEn  = accept ? reqByteEn : heldByteEn;
  wire logic [0:ROM_ADDR_W-1] curRomAddr = accept ? reqRomAddr : heldRomAddr;
  wire logic [0:PARITY_W-1]   curWrParity = accept ? reqWrParity : heldWrParity;
  wire logic                  curRefresh = refreshTaken | (refreshCycle & ~accept);

  wire logic nsRow  = (nextState == ST_ROW);
  wire logic nsCol  = (nextState == ST_COL);
  wire logic nsPre  = (nextState == ST_PRE);
  wire logic nsRom  = (nextState == ST_ROM);
  wire logic nsRef  = (nextState == ST_REF);
  wire logic nsIdle = (nextState == ST_IDLE);
  wire logic cntZero = (cnt == '0);

  // edo parts keep data valid after the column strobe rises, so the read
  // latches stay open through all six precharge cycles
  wire logic edoHold  = nsPre & ramIsEdo & ~curRefresh & ~curWrite;
  wire logic dramRead = ~curWrite & (nsCol | edoHold);
  wire logic romRead  = nsRom & ~curWrite;

  logic [0:STROBE_N-1] next_rowStrobeB;
  logic [0:STROBE_N-1] next_colStrobeB;
  wire logic [0:ADDR_W-1] next_memAddr;
  wire logic [0:PARITY_W-1] romLow;

  wire logic next_memWriteEnB =
    ~(curWrite & (nsRow | nsCol | (nsRom & romIsFlash)));
  wire logic next_flashOutEnB  = ~(romRead & romIsFlash);
  wire logic next_romBank0SelB = ~(nsRom & ~curRomBank);
  wire logic next_romBank1SelB = ~(nsRom & curRomBank);
  wire logic next_memDataLatchEn = dramRead | romRead;
  wire logic next_parityPathRdEn = dramRead;
  wire logic next_bufDir = curWrite & (nsCol | nsRom);
  wire logic next_bufEn  = nsCol | nsRom | edoHold;
  // the parity lines double as rom address pins, so they drive on any rom cycle
  wire logic next_parityOe = nsRom | (curWrite & (nsRow | nsCol));
  wire logic [0:PARITY_W-1] next_parityOut = nsRom ? romLow : curWrParity;
  wire logic next_reqReady = nsIdle & ~suspend & ~refreshPending & ~refreshTaken;
  wire logic next_rspDone = ((state == ST_COL) | (state == ST_ROM)) & cntZero & ~refreshCycle;
  wire logic captureParity = (state == ST_COL) & cntZero & ~heldWrite;

  genvar g;
  generate
    for (g = 0; g < STROBE_N; g++) begin : gStrobe
      always_comb begin
        next_rowStrobeB[g] = ~(nsRef | ((nsRow | nsCol) & (curBank == BANK_W'(g))));
        next_colStrobeB[g] = ~(nsCol & curByteEn[g]);
      end
    end
  endgenerate

  mem_addr_map uAddrMap (
    .romSel     (nsRom),
    .colSel     (nsCol),
    .refSel     (nsRef),
    .extraBitOk (romBank0Byte & ~curRomBank),
    .rowAddr    (curRow),
    .colAddr    (curCol),
    .refRow     (refRow),
    .romAddr    (curRomAddr),
    .memAddr    (next_memAddr),
    .romLow     (romLow)
  );

  refresh_tick #(
    .REFI (REFI)
  ) uRefresh (
    .sys_clk        (sys_clk),
    .rst_b          (rst_b),
    .suspend        (suspend),
    .refreshSlowClk (refreshSlowClk),
    .refreshTaken   (refreshTaken),
    .refreshPending (refreshPending)
  );

  // sequencing: row phase, column phase, precharge; rom and refresh apart
  always_comb begin
    nextState    = state;
    nextCnt      = cntZero ? cnt : cnt - CNT_W'(1);
    accept       = 1'b0;
    refuse       = 1'b0;
    refreshTaken = 1'b0;
    case (state)
      ST_IDLE: begin
        // ready was promised at the last edge, so a request seen now is honoured;
        // a refresh raised in this same cycle waits one access for the next idle
        if (reqValid && reqReady) begin
          if (reqRom && reqWrite && !romIsFlash) begin
            // plain rom cannot be written; answered without touching the pins
            refuse = 1'b1;
          end else if (reqRom) begin
            accept    = 1'b1;
            nextState = ST_ROM;
            nextCnt   = CNT_W'(ROM_CYC - 1);
          end else begin
            accept    = 1'b1;
            nextState = ST_ROW;
            nextCnt   = CNT_W'(RCD_CYC - 1);
          end
        end else if (refreshPending) begin
          nextState    = ST_REF;
          nextCnt      = CNT_W'(REF_CYC - 1);
          refreshTaken = 1'b1;
        end
      end
      ST_ROW: begin
        if (cntZero) begin
          nextState = ST_COL;
          nextCnt   = CNT_W'(CAS_CYC - 1);
        end
      end
      ST_COL: begin
        if (cntZero) begin
          nextState = ST_PRE;
          nextCnt   = CNT_W'(RP_CYC - 1);
        end
      end
      ST_REF: begin
        if (cntZero) begin
          nextState = ST_PRE;
          nextCnt   = CNT_W'(RP_CYC - 1);
        end
      end
      ST_PRE: begin
        if (cntZero) begin
          nextState = ST_IDLE;
        end
      end
      ST_ROM: begin
        if (cntZero) begin
          nextState = ST_IDLE;
        end
      end
      default: begin
        nextState = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state        <= ST_IDLE;
      cnt          <= '0;
      refreshCycle <= 1'b0;
      refRow       <= ADDR_RST;
    end else begin
      state        <= nextState;
      cnt          <= nextCnt;
      refreshCycle <= curRefresh;
      if (refreshTaken) begin
        refRow <= refRow + ADDR_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      heldWrite    <= 1'b0;
      heldRom      <= 1'b0;
      heldRomBank  <= 1'b0;
      heldBank     <= '0;
      heldRow      <= ADDR_RST;
      heldCol      <= ADDR_RST;
      heldByteEn   <= '0;
      heldRomAddr  <= '0;
      heldWrParity <= PARITY_RST;
    end else if (accept) begin
      heldWrite    <= reqWrite;
      heldRom      <= reqRom;
      heldRomBank  <= reqRomBank;
      heldBank     <= reqBank;
      heldRow      <= reqRowAddr;
      heldCol      <= reqColAddr;
      heldByteEn   <= reqByteEn;
      heldRomAddr  <= reqRomAddr;
      heldWrParity <= reqWrParity;
    end
  end

  // every pin comes straight from a flop
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      memAddr        <= ADDR_RST;
      rowStrobeB     <= STROBE_OFF;
      colStrobeB     <= STROBE_OFF;
      memWriteEnB    <= 1'b1;
      flashOutEnB    <= 1'b1;
      romBank0SelB   <= 1'b1;
      romBank1SelB   <= 1'b1;
      memDataLatchEn <= 1'b0;
      parityPathRdEn <= 1'b0;
      bufferCtrl     <= 2'h0;
      parityOut      <= PARITY_RST;
      parityOe       <= 1'b0;
    end else begin
      memAddr        <= next_memAddr;
      rowStrobeB     <= next_rowStrobeB;
      colStrobeB     <= next_colStrobeB;
      memWriteEnB    <= next_memWriteEnB;
      flashOutEnB    <= next_flashOutEnB;
      romBank0SelB   <= next_romBank0SelB;
      romBank1SelB   <= next_romBank1SelB;
      memDataLatchEn <= next_memDataLatchEn;
      parityPathRdEn <= next_parityPathRdEn;
      bufferCtrl[BUF_DIR_BIT] <= next_bufDir;
      bufferCtrl[BUF_EN_BIT]  <= next_bufEn;
      parityOut      <= next_parityOut;
      parityOe       <= next_parityOe;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reqReady   <= 1'b0;
      rspDone    <= 1'b0;
      rspRefused <= 1'b0;
      rspParity  <= PARITY_RST;
    end else begin
      reqReady   <= next_reqReady;
      rspDone    <= next_rspDone | refuse;
      rspRefused <= refuse;
      if (captureParity) begin
        rspParity <= parityIn;
      end
    end
  end

endmodule
`default_nettype wire

// ---- logic/mem_addr_map.sv ----
// address pin mapping for dram row, column, refresh row and rom accesses
`timescale 1ns/10ps
`default_nettype none
module mem_addr_map
  import mem_if_pkg::*;
(
  input  wire logic                romSel,
  input  wire logic                colSel,
  input  wire logic                refSel,
  input  wire logic                extraBitOk,
  input  wire logic [0:ADDR_W-1]   rowAddr,
  input  wire logic [0:ADDR_W-1]   colAddr,
  input  wire logic [0:ADDR_W-1]   refRow,
  input  wire logic [0:ROM_ADDR_W-1] romAddr,
  output logic      [0:ADDR_W-1]   memAddr,
  output logic      [0:PARITY_W-1] romLow
);

  wire logic [0:ADDR_W-1] romOnPins;
  wire logic [0:ADDR_W-1] dramAddr;

  // extra top bit only reaches the pin for a byte wide bank 0
  assign romOnPins[0] = extraBitOk & romAddr[ROM_EXTRA_BIT];
  assign romOnPins[1:ADDR_W-1] = romAddr[ROM_HIGH_FIRST:ROM_HIGH_LAST];
  assign romLow   = romAddr[ROM_LOW_FIRST:ROM_LOW_LAST];
  assign dramAddr = refSel ? refRow : (colSel ? colAddr : rowAddr);
  assign memAddr  = romSel ? romOnPins : dramAddr;

endmodule
`default_nettype wire

// ---- logic/mem_if_pkg.sv ----
// shared constants, timing counts and state type for the memory pin interface
package mem_if_pkg;

  localparam int CLK_MHZ      = 200;

  localparam int ADDR_W       = 13;
  localparam int STROBE_N     = 8;
  localparam int PARITY_W     = 8;
  localparam int BANK_W       = 3;
  localparam int ROM_ADDR_W   = 21;
  localparam int CNT_W        = 8;
  localparam int REFI_W       = 16;

  // rom address bit positions, bit 0 is the most significant
  localparam int ROM_EXTRA_BIT = 0;
  localparam int ROM_LOW_FIRST = 1;
  localparam int ROM_LOW_LAST  = 8;
  localparam int ROM_HIGH_FIRST = 9;
  localparam int ROM_HIGH_LAST = 20;

  // buffer control field positions
  localparam int BUF_DIR_BIT  = 0;
  localparam int BUF_EN_BIT   = 1;

  // timing in ns, least times round up, the refresh interval rounds down
  localparam int T_RCD_NS     = 20;
  localparam int T_CAS_NS     = 20;
  localparam int T_RP_NS      = 30;
  localparam int T_RAS_REF_NS = 60;
  localparam int T_ROM_NS     = 120;
  localparam int T_REFI_NS    = 15600;

  localparam int RCD_RAW      = (T_RCD_NS * CLK_MHZ + 999) / 1000;
  localparam int CAS_RAW      = (T_CAS_NS * CLK_MHZ + 999) / 1000;
  localparam int RP_RAW       = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int REF_RAW      = (T_RAS_REF_NS * CLK_MHZ + 999) / 1000;
  localparam int ROM_RAW      = (T_ROM_NS * CLK_MHZ + 999) / 1000;
  localparam int REFI_RAW     = (T_REFI_NS * CLK_MHZ) / 1000;

  localparam int RCD_CYC      = (RCD_RAW < 1) ? 1 : RCD_RAW;
  localparam int CAS_CYC      = (CAS_RAW < 1) ? 1 : CAS_RAW;
  localparam int RP_CYC       = (RP_RAW < 1) ? 1 : RP_RAW;
  localparam int REF_CYC      = (REF_RAW < 1) ? 1 : REF_RAW;
  localparam int ROM_CYC      = (ROM_RAW < 1) ? 1 : ROM_RAW;
  localparam int REFI_CYC     = (REFI_RAW < 1) ? 1 : REFI_RAW;

  localparam logic [ADDR_W-1:0]   ADDR_RST   = 13'h0000;
  localparam logic [PARITY_W-1:0] PARITY_RST = 8'h00;
  localparam logic [STROBE_N-1:0] STROBE_OFF = 8'hff;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ROW,
    ST_COL,
    ST_PRE,
    ST_ROM,
    ST_REF
  } mem_state_t;

endpackage

// ---- logic/refresh_tick.sv ----
// refresh request source: internal interval divider, or slow clock edges in suspend
`timescale 1ns/10ps
`default_nettype none
module refresh_tick
  import mem_if_pkg::*;
#(
  parameter int REFI = REFI_CYC
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic suspend,
  input  wire logic refreshSlowClk,
  input  wire logic refreshTaken,
  output logic      refreshPending
);

  logic [REFI_W-1:0] divCnt;
  logic              slowLast;
  wire logic         divWrap  = (divCnt == REFI_W'(REFI - 1));
  wire logic         slowRise = refreshSlowClk & ~slowLast;
  // in suspend the fast divider is idle and only the slow clock paces refresh
  wire logic         tick     = suspend ? slowRise : divWrap;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt <= '0;
    end else if (suspend || divWrap) begin
      divCnt <= '0;
    end else begin
      divCnt <= divCnt + REFI_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      slowLast       <= 1'b0;
      refreshPending <= 1'b0;
    end else begin
      slowLast       <= refreshSlowClk;
      // a new tick in the taking cycle is kept
      refreshPending <= tick | (refreshPending & ~refreshTaken);
    end
  end

endmodule
`default_nettype wire
